// ---- common/isd_regs.vh ----
`ifndef ISD_REGS_VH
`define ISD_REGS_VH

// special register numbers of the two alias registers
`define ISD_SR_BYTE_POINTER   8'h85
`define ISD_SR_SHIFT_COUNT    8'h86
// alu status register number (pointer and count fields live there)
`define ISD_SR_ALU_STATUS     8'h84

// field positions inside the alu status register view
`define ISD_STAT_BP_LSB       5
`define ISD_STAT_BP_MSB       6
`define ISD_STAT_FC_LSB       0
`define ISD_STAT_FC_MSB       4
`define ISD_STAT_OTHER_MASK   32'hffffff80

// reset values
`define ISD_BP_RESET          2'h0
`define ISD_FC_RESET          5'h00
`define ISD_STAT_RESET        32'h00000000
// value written into the pointer by loads and stores with set bit
`define ISD_BP_SET_VALUE      2'h3

// load/store instruction: set-pointer / sign bit position
`define ISD_LS_SB_BIT         20

// operation codes on the op input
`define ISD_OP_NONE           5'h00
`define ISD_OP_BYTE_EXTRACT   5'h01
`define ISD_OP_BYTE_INSERT    5'h02
`define ISD_OP_BYTE_COMPARE   5'h03
`define ISD_OP_HALF_EXTRACT   5'h04
`define ISD_OP_HALF_EXTR_S    5'h05
`define ISD_OP_HALF_INSERT    5'h06
`define ISD_OP_FUNNEL         5'h07
`define ISD_OP_CONST          5'h08
`define ISD_OP_CONST_HIGH     5'h09
`define ISD_OP_CONST_NEG      5'h0a
`define ISD_OP_LOAD_BYTE      5'h0b
`define ISD_OP_LOAD_HALF      5'h0c
`define ISD_OP_STORE_BYTE     5'h0d
`define ISD_OP_STORE_HALF     5'h0e
`define ISD_OP_STORE_WORD     5'h0f
`define ISD_OP_LOAD_WORD      5'h10
`define ISD_OP_WRITE_SR       5'h11
`define ISD_OP_READ_SR        5'h12
`define ISD_OP_COMPARE_EQ     5'h13

`endif

// ---- rtl/isd_datapath.v ----
// Overview of operation
// - bytes and half-words numbered big-endian, left first
// - loads convert packed items to signed/unsigned
// - byte store packs low byte into lane
// - half store packs low half into lane
// - byte extract replaces lowest destination byte
// - byte insert writes low byte into pointed byte
// - byte compare true if any bytes equal
// - half extract replaces low half, pointer top
// - signed half extract also sign-fills upper
// - half insert writes low half into chosen half
// - pointer is two bits, upper alias bits zero
// - half operations use only pointer top bit
// - pointer alias shares status field storage
// - pointer written by move to special register
// - load/store with set bit writes pointer 11
// - funnel joins operands, shifts, returns 32 bits
// - shift count five bits, upper alias zero
// - count written via status or alias
// - compare true in msb, other bits zero
// - constant loads low half, clears upper
// - high constant sets upper, keeps lower
// - negative constant loads low, sets upper ones
// - instruction bit 20 selects sign extension
`timescale 1ns/100ps
`default_nettype none
`include "isd_regs.vh"

module isd_datapath (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_reset,
    // operation from the sequencer
    input  wire        i_valid,
    input  wire [4:0]  i_op,
    input  wire [31:0] i_instr,
    input  wire [7:0]  i_sr_num,
    // operands from the register file
    input  wire [31:0] i_src_a,
    input  wire [31:0] i_src_b,
    input  wire [31:0] i_dest,
    // external load data
    input  wire [31:0] i_load_data,
    input  wire [1:0]  i_load_lane,
    // store lane select
    input  wire [1:0]  i_store_lane,
    // result back to the register file
    output reg         o_result_valid,
    output reg  [31:0] o_result,
    // external store word
    output reg         o_store_valid,
    output wire [31:0] o_store_data,
    output wire [3:0]  o_store_lanes,
    // special register state
    output reg  [1:0]  o_byte_pointer,
    output reg  [4:0]  o_shift_count,
    output reg  [31:0] o_alu_status
);

    // pointer and count fields of the alu status register
    reg  [1:0]  byte_pointer;
    reg  [4:0]  shift_count;
    reg  [31:0] status_other;
    reg  [31:0] next_result;
    reg         next_result_valid;
    reg  [1:0]  next_pointer;
    reg  [4:0]  next_count;
    reg  [31:0] next_other;
    reg         funnel_pending;
    reg         funnel_pending_q;
    wire [31:0] funnel_result;
    wire        set_bit;
    wire        is_store;

    // pick byte n counted from the left end
    function [7:0] pick_byte;
        input [31:0] word;
        input [1:0]  idx;
        begin
            case (idx)
                2'h0:    pick_byte = word[31:24];
                2'h1:    pick_byte = word[23:16];
                2'h2:    pick_byte = word[15:8];
                default: pick_byte = word[7:0];
            endcase
        end
    endfunction

    // pick left (0) or right (1) half-word
    function [15:0] pick_half;
        input [31:0] word;
        input        sel;
        begin
            pick_half = sel ? word[15:0] : word[31:16];
        end
    endfunction

    // compose the alu status register view
    function [31:0] status_view;
        input [31:0] other;
        input [1:0]  bp;
        input [4:0]  fc;
        begin
            status_view = other & `ISD_STAT_OTHER_MASK;
            status_view[`ISD_STAT_BP_MSB:`ISD_STAT_BP_LSB] = bp;
            status_view[`ISD_STAT_FC_MSB:`ISD_STAT_FC_LSB] = fc;
        end
    endfunction

    assign set_bit  = i_instr[`ISD_LS_SB_BIT];
    assign is_store = (i_op == `ISD_OP_STORE_BYTE) ||
                      (i_op == `ISD_OP_STORE_HALF) ||
                      (i_op == `ISD_OP_STORE_WORD);

    // funnel shifter sees the current count; result lands a cycle later
    isd_funnel #(
        .WIDTH (32),
        .CW    (5)
    ) u_funnel (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_high   (i_src_a),
        .i_low    (i_src_b),
        .i_count  (shift_count),
        .o_result (funnel_result)
    );

    // store lane packing, also registered
    isd_lane u_lane (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_half  (i_op == `ISD_OP_STORE_HALF),
        .i_word  (i_op == `ISD_OP_STORE_WORD),
        .i_lane  (i_store_lane),
        .i_data  (i_src_a),
        .o_data  (o_store_data),
        .o_lanes (o_store_lanes)
    );

    // result and special register next values
    always @* begin
        next_result       = i_dest;
        next_result_valid = 1'b0;
        next_pointer      = byte_pointer;
        next_count        = shift_count;
        next_other        = status_other;
        funnel_pending    = 1'b0;
        if (i_valid) begin
            next_result_valid = 1'b1;
            case (i_op)
                `ISD_OP_BYTE_EXTRACT: begin
                    next_result = {i_dest[31:8],
                                   pick_byte(i_src_a, byte_pointer)};
                end
                `ISD_OP_BYTE_INSERT: begin
                    // source may carry the instruction's 8-bit constant
                    next_result = i_dest;
                    case (byte_pointer)
                        2'h0:    next_result[31:24] = i_src_a[7:0];
                        2'h1:    next_result[23:16] = i_src_a[7:0];
                        2'h2:    next_result[15:8]  = i_src_a[7:0];
                        default: next_result[7:0]   = i_src_a[7:0];
                    endcase
                end
                `ISD_OP_BYTE_COMPARE: begin
                    next_result = {((i_src_a[31:24] == i_src_b[31:24]) ||
                                    (i_src_a[23:16] == i_src_b[23:16]) ||
                                    (i_src_a[15:8]  == i_src_b[15:8])  ||
                                    (i_src_a[7:0]   == i_src_b[7:0])),
                                   31'h00000000};
                end
                `ISD_OP_COMPARE_EQ: begin
                    next_result = {(i_src_a == i_src_b),
                                   31'h00000000};
                end
                `ISD_OP_HALF_EXTRACT: begin
                    next_result = {i_dest[31:16],
                        pick_half(i_src_a, byte_pointer[1])};
                end
                `ISD_OP_HALF_EXTR_S: begin
                    next_result[15:0]  = pick_half(i_src_a,
                                                   byte_pointer[1]);
                    next_result[31:16] = {16{next_result[15]}};
                end
                `ISD_OP_HALF_INSERT: begin
                    next_result = i_dest;
                    if (byte_pointer[1]) begin
                        next_result[15:0] = i_src_a[15:0];
                    end else begin
                        next_result[31:16] = i_src_a[15:0];
                    end
                end
                `ISD_OP_FUNNEL: begin
                    // result comes from the shifter register next cycle
                    next_result_valid = 1'b0;
                    funnel_pending    = 1'b1;
                end
                `ISD_OP_CONST: begin
                    next_result = {16'h0000, i_instr[15:0]};
                end
                `ISD_OP_CONST_HIGH: begin
                    next_result = {i_instr[15:0], i_dest[15:0]};
                end
                `ISD_OP_CONST_NEG: begin
                    next_result = {16'hffff, i_instr[15:0]};
                end
                `ISD_OP_LOAD_BYTE: begin
                    next_result[7:0]  = pick_byte(i_load_data,
                                                  i_load_lane);
                    next_result[31:8] = {24{set_bit & next_result[7]}};
                    // sign only when bit 20 is set
                end
                `ISD_OP_LOAD_HALF: begin
                    next_result[15:0]  = pick_half(i_load_data,
                                                   i_load_lane[1]);
                    next_result[31:16] = {16{set_bit & next_result[15]}};
                end
                `ISD_OP_LOAD_WORD: begin
                    next_result = i_load_data;
                end
                `ISD_OP_WRITE_SR: begin
                    next_result_valid = 1'b0;
                    if (i_sr_num == `ISD_SR_BYTE_POINTER) begin
                        next_pointer = i_src_a[1:0];
                    end else if (i_sr_num == `ISD_SR_SHIFT_COUNT) begin
                        next_count = i_src_a[4:0];
                    end else if (i_sr_num == `ISD_SR_ALU_STATUS) begin
                        next_pointer = i_src_a[`ISD_STAT_BP_MSB:
                                               `ISD_STAT_BP_LSB];
                        next_count   = i_src_a[`ISD_STAT_FC_MSB:
                                               `ISD_STAT_FC_LSB];
                        next_other   = i_src_a & `ISD_STAT_OTHER_MASK;
                    end
                end
                `ISD_OP_READ_SR: begin
                    // aliases read with zero upper bits
                    if (i_sr_num == `ISD_SR_BYTE_POINTER) begin
                        next_result = {30'h00000000, byte_pointer};
                    end else if (i_sr_num == `ISD_SR_SHIFT_COUNT) begin
                        next_result = {27'h0000000, shift_count};
                    end else if (i_sr_num == `ISD_SR_ALU_STATUS) begin
                        next_result = status_view(status_other,
                                                  byte_pointer, shift_count);
                    end else begin
                        next_result = 32'h00000000;
                    end
                end
                default: begin
                    next_result_valid = 1'b0;
                end
            endcase
            // loads and stores with the set bit force the pointer
            if ((i_op == `ISD_OP_LOAD_BYTE || i_op == `ISD_OP_LOAD_HALF ||
                 i_op == `ISD_OP_LOAD_WORD || is_store) && set_bit) begin
                next_pointer = `ISD_BP_SET_VALUE;
            end
        end
        // shifter word lands two edges after issue; an op issued
        // right behind a funnel op loses its result, so the
        // sequencer idles one cycle after it, which spares a
        // second result register
        if (funnel_pending_q) begin
            next_result       = funnel_result;
            next_result_valid = 1'b1;
        end
    end

    // state and registered outputs
    always @(posedge i_clk) begin
        if (i_reset) begin
            byte_pointer     <= `ISD_BP_RESET;
            shift_count      <= `ISD_FC_RESET;
            status_other     <= `ISD_STAT_RESET;
            funnel_pending_q <= 1'b0;
            o_result_valid   <= 1'b0;
            o_result         <= 32'h00000000;
            o_store_valid    <= 1'b0;
            o_byte_pointer   <= `ISD_BP_RESET;
            o_shift_count    <= `ISD_FC_RESET;
            o_alu_status     <= `ISD_STAT_RESET;
        end else begin
            byte_pointer     <= next_pointer;
            shift_count      <= next_count;
            status_other     <= next_other;
            funnel_pending_q <= funnel_pending;
            o_result_valid   <= next_result_valid;
            o_result         <= next_result;
            o_store_valid    <= i_valid & is_store;
            o_byte_pointer   <= next_pointer;
            o_shift_count    <= next_count;
            o_alu_status     <= status_view(next_other, next_pointer,
                                            next_count);
        end
    end

endmodule // isd_datapath

`default_nettype wire

// ---- rtl/isd_funnel.v ----
`timescale 1ns/100ps
`default_nettype none

// 64-to-32 funnel shifter, result registered
module isd_funnel #(
    parameter WIDTH = 32,
    parameter CW    = 5
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_reset,
    // operands
    input  wire [WIDTH-1:0] i_high,
    input  wire [WIDTH-1:0] i_low,
    input  wire [CW-1:0]    i_count,
    // result
    output reg  [WIDTH-1:0] o_result
);

    wire [2*WIDTH-1:0] joined;
    wire [2*WIDTH-1:0] shifted;

    // count measures from the top of the joined value
    assign joined  = {i_high, i_low};
    assign shifted = joined << i_count;

    // register the upper word of the shifted value
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_result <= {WIDTH{1'b0}};
        end else begin
            o_result <= shifted[2*WIDTH-1:WIDTH];
        end
    end

endmodule // isd_funnel

`default_nettype wire

// ---- rtl/isd_lane.v ----
`timescale 1ns/100ps
`default_nettype none

// big-endian lane packing for stores, registered
module isd_lane (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_reset,
    // store request
    input  wire        i_half,
    input  wire        i_word,
    input  wire [1:0]  i_lane,
    input  wire [31:0] i_data,
    // external word and byte enables (bit 3 = leftmost byte)
    output reg  [31:0] o_data,
    output reg  [3:0]  o_lanes
);

    reg [31:0] next_data;
    reg [3:0]  next_lanes;

    // lane 0 is the most significant byte
    always @* begin
        next_data  = i_data;
        next_lanes = 4'hf;
        if (i_word) begin
            next_data  = i_data;
            next_lanes = 4'hf;
        end else if (i_half) begin
            next_data  = {2{i_data[15:0]}};
            next_lanes = i_lane[1] ? 4'h3 : 4'hc;
        end else begin
            next_data  = {4{i_data[7:0]}};
            next_lanes = 4'h8 >> i_lane;
        end
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            o_data  <= 32'h00000000;
            o_lanes <= 4'h0;
        end else begin
            o_data  <= next_data;
            o_lanes <= next_lanes;
        end
    end

endmodule // isd_lane

`default_nettype wire

// ---- tb/isd_datapath_props.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "isd_regs.vh"
module isd_datapath_props (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_reset,
    // sequencer and operands
    input wire logic        i_valid,
    input wire logic [4:0]  i_op,
    input wire logic [31:0] i_instr,
    input wire logic [7:0]  i_sr_num,
    input wire logic [31:0] i_src_a,
    input wire logic [31:0] i_src_b,
    input wire logic [31:0] i_dest,
    input wire logic [1:0]  i_store_lane,
    // design outputs
    input wire logic        o_result_valid,
    input wire logic [31:0] o_result,
    input wire logic        o_store_valid,
    input wire logic [3:0]  o_store_lanes,
    input wire logic [1:0]  o_byte_pointer,
    input wire logic [4:0]  o_shift_count,
    input wire logic [31:0] o_alu_status
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire any_eq;
    wire is_ls;
    // any byte lane equal; load/store codes form one range
    assign any_eq = (i_src_a[31:24] == i_src_b[31:24])
        | (i_src_a[23:16] == i_src_b[23:16])
        | (i_src_a[15:8] == i_src_b[15:8]) | (i_src_a[7:0] == i_src_b[7:0]);
    assign is_ls = (i_op >= `ISD_OP_LOAD_BYTE) && (i_op <= `ISD_OP_LOAD_WORD);
    sequence s_issue(logic [4:0] code);
        i_valid && i_op == code;
    endsequence
    sequence s_count_write;
        s_issue(`ISD_OP_WRITE_SR) ##0 i_sr_num == `ISD_SR_SHIFT_COUNT;
    endsequence
    property p_const;
        s_issue(`ISD_OP_CONST) |=> o_result_valid
            && o_result == {16'h0000, $past(i_instr[15:0])};
    endproperty
    a_const: assert property (p_const) else $error("constant wrong");
    property p_const_high;
        s_issue(`ISD_OP_CONST_HIGH) |=>
            o_result == {$past(i_instr[15:0]), $past(i_dest[15:0])};
    endproperty
    a_const_high: assert property (p_const_high) else $error("high const");
    property p_const_neg;
        s_issue(`ISD_OP_CONST_NEG) |=>
            o_result == {16'hffff, $past(i_instr[15:0])};
    endproperty
    a_const_neg: assert property (p_const_neg) else $error("neg const");
    property p_byte_cmp;
        s_issue(`ISD_OP_BYTE_COMPARE) |=> o_result[30:0] == 31'h0
            && o_result[31] == $past(any_eq);
    endproperty
    a_byte_cmp: assert property (p_byte_cmp) else $error("byte compare");
    property p_ptr_set;
        i_valid && is_ls && i_instr[`ISD_LS_SB_BIT] |=> o_byte_pointer == 2'h3;
    endproperty
    a_ptr_set: assert property (p_ptr_set) else $error("pointer set");
    property p_alias;
        o_alu_status[6:0] == {o_byte_pointer, o_shift_count};
    endproperty
    a_alias: assert property (p_alias) else $error("alias view");
    property p_count_write;
        s_count_write |=> o_shift_count == $past(i_src_a[4:0])
            && o_alu_status[31:7] == $past(o_alu_status[31:7])
            && $stable(o_byte_pointer);
    endproperty
    a_count_write: assert property (p_count_write) else $error("count");
    property p_idle;
        !i_valid && !$past(i_valid && i_op == `ISD_OP_FUNNEL)
            |=> !o_result_valid && !o_store_valid;
    endproperty
    a_idle: assert property (p_idle) else $error("spurious pulse");
    property p_store_lane;
        s_issue(`ISD_OP_STORE_BYTE) |=> o_store_valid
            && o_store_lanes == (4'b1000 >> $past(i_store_lane));
    endproperty
    a_store_lane: assert property (p_store_lane) else $error("lane");
    property p_half_sign;
        s_issue(`ISD_OP_HALF_EXTR_S) |=> o_result[31:16] == {16{o_result[15]}};
    endproperty
    a_half_sign: assert property (p_half_sign) else $error("sign fill");
    wire [63:0] funnel_exp;
    assign funnel_exp = {i_src_a, i_src_b} << o_shift_count;
    property p_funnel;
        s_issue(`ISD_OP_FUNNEL) |=> ##1 o_result_valid
            && o_result == $past(funnel_exp[63:32], 2);
    endproperty
    a_funnel: assert property (p_funnel) else $error("funnel");
endmodule // isd_datapath_props
bind isd_datapath isd_datapath_props u_props (.i_clk(i_clk),
    .i_reset(i_reset), .i_valid(i_valid), .i_op(i_op), .i_instr(i_instr),
    .i_sr_num(i_sr_num), .i_src_a(i_src_a), .i_src_b(i_src_b),
    .i_dest(i_dest), .i_store_lane(i_store_lane),
    .o_result_valid(o_result_valid), .o_result(o_result),
    .o_store_valid(o_store_valid), .o_store_lanes(o_store_lanes),
    .o_byte_pointer(o_byte_pointer), .o_shift_count(o_shift_count),
    .o_alu_status(o_alu_status));
`default_nettype wire

// ---- tb/isd_regfile.sv ----
`timescale 1ns/100ps
`default_nettype none
// one register file slot that feeds the old destination back
module isd_regfile (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // write-back from the datapath
    input  wire logic        i_we,
    input  wire logic [31:0] i_wdata,
    // destination operand for the next op
    output logic      [31:0] o_rdata
);
    // write lands on the edge after the pulse, as in the real file
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 32'h0;
        end else if (i_we) begin
            o_rdata <= i_wdata;
        end
    end
endmodule // isd_regfile
`default_nettype wire

// ---- tb/test_integer_subword_datapath.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "isd_regs.vh"
module test_integer_subword_datapath;
    // stimulus, driven at the falling edge
    logic        i_clk = 1'b0, i_reset = 1'b1, i_valid = 1'b0;
    logic [4:0]  i_op = 5'h00;
    logic [7:0]  i_sr_num = 8'h00;
    logic [1:0]  i_load_lane = 2'h0, i_store_lane = 2'h0;
    logic [31:0] i_instr = 32'h0, i_src_a = 32'h0, i_src_b = 32'h0;
    logic [31:0] i_load_data = 32'h0;
    wire         o_result_valid, o_store_valid;
    wire  [31:0] dest, o_result, o_store_data, o_alu_status;
    wire  [3:0]  o_store_lanes;
    wire  [1:0]  o_byte_pointer;
    wire  [4:0]  o_shift_count;
    int          fails = 0, checked = 0;
    always #2.5 i_clk = ~i_clk;
    isd_datapath u_isd_datapath (
        .i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid), .i_op(i_op),
        .i_instr(i_instr), .i_sr_num(i_sr_num), .i_src_a(i_src_a),
        .i_src_b(i_src_b), .i_dest(dest), .i_load_data(i_load_data),
        .i_load_lane(i_load_lane), .i_store_lane(i_store_lane),
        .o_result_valid(o_result_valid), .o_result(o_result),
        .o_store_valid(o_store_valid), .o_store_data(o_store_data),
        .o_store_lanes(o_store_lanes), .o_byte_pointer(o_byte_pointer),
        .o_shift_count(o_shift_count), .o_alu_status(o_alu_status));
    isd_regfile u_isd_regfile (.i_clk(i_clk), .i_reset(i_reset),
        .i_we(o_result_valid), .i_wdata(o_result), .o_rdata(dest));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one op, outputs are sampled at the falling edge after the take
    task automatic op(input logic [4:0] code, input logic [31:0] ins, a, b);
        @(negedge i_clk);
        i_valid = 1'b1;
        i_op = code;
        i_instr = ins;
        i_src_a = a;
        i_src_b = b;
        @(negedge i_clk);
        i_valid = 1'b0;
    endtask
    task automatic wsr(input logic [7:0] num, input logic [31:0] val);
        i_sr_num = num;
        op(`ISD_OP_WRITE_SR, 32'h0, val, val);
    endtask
    task automatic rsr(input logic [7:0] num);
        i_sr_num = num;
        op(`ISD_OP_READ_SR, 32'h0, 32'h0, 32'h0);
    endtask
    // the register file slot takes both halves by write-back
    task automatic set_dest(input logic [31:0] v);
        op(`ISD_OP_CONST, {16'h0, v[15:0]}, 32'h0, 32'h0);
        op(`ISD_OP_CONST_HIGH, {16'h0, v[31:16]}, 32'h0, 32'h0);
    endtask
    function automatic logic [31:0] mask(input logic [3:0] m);
        return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction
    task automatic t_const;
        op(`ISD_OP_CONST, 32'hffff8001, 32'h0, 32'h0);
        chk(o_result, 32'h00008001);
        op(`ISD_OP_CONST_HIGH, 32'h0000a5c3, 32'h0, 32'h0);
        chk(o_result, 32'ha5c38001);
        op(`ISD_OP_CONST_NEG, 32'h00001234, 32'h0, 32'h0);
        chk(o_result, 32'hffff1234);
        $display("t_const finished");
    endtask
    task automatic t_sr;
        wsr(`ISD_SR_BYTE_POINTER, 32'hfffffffe);
        rsr(`ISD_SR_BYTE_POINTER);
        chk(o_result, 32'h00000002);
        wsr(`ISD_SR_SHIFT_COUNT, 32'hffffffed);
        rsr(`ISD_SR_SHIFT_COUNT);
        chk(o_result, 32'h0000000d);
        chk({25'h0, o_alu_status[6:0]}, 32'h0000004d);
        wsr(`ISD_SR_ALU_STATUS, 32'hf0000067);
        chk({25'h0, o_byte_pointer, o_shift_count}, 32'h67);
        wsr(`ISD_SR_BYTE_POINTER, 32'h1);
        chk(o_alu_status, 32'hf0000027);
        rsr(`ISD_SR_ALU_STATUS);
        chk(o_result, 32'hf0000027);
        $display("t_sr finished");
    endtask
    task automatic t_byte;
        logic [31:0] exp;
        for (int p = 0; p < 4; p++) begin
            wsr(`ISD_SR_BYTE_POINTER, 32'(p));
            set_dest(32'h11223344);
            op(`ISD_OP_BYTE_EXTRACT, 32'h0, 32'haabbccdd, 32'haabbccdd);
            exp = {24'h112233, 8'(32'haabbccdd >> (8 * (3 - p)))};
            chk(o_result, exp);
            set_dest(32'h11223344);
            op(`ISD_OP_BYTE_INSERT, 32'h5a, 32'h5a, 32'h5a);
            exp = 32'h11223344;
            exp[31 - 8 * p -: 8] = 8'h5a;
            chk(o_result, exp);
        end
        $display("t_byte finished");
    endtask
    task automatic t_half;
        logic [15:0] h;
        for (int p = 0; p < 4; p++) begin
            h = p[1] ? 16'h4321 : 16'h8765;
            wsr(`ISD_SR_BYTE_POINTER, 32'(p));
            set_dest(32'h11223344);
            op(`ISD_OP_HALF_EXTRACT, 32'h0, 32'h87654321, 32'h87654321);
            chk(o_result, {16'h1122, h});
            set_dest(32'h11223344);
            op(`ISD_OP_HALF_EXTR_S, 32'h0, 32'h87654321, 32'h87654321);
            chk(o_result, {{16{h[15]}}, h});
            set_dest(32'h11223344);
            op(`ISD_OP_HALF_INSERT, 32'h0, 32'h87654321, 32'h87654321);
            chk(o_result, p[1] ? 32'h11224321 : 32'h43213344);
        end
        $display("t_half finished");
    endtask
    task automatic t_load;
        i_load_data = 32'h12f486f8;
        for (int s = 0; s < 2; s++) begin
            wsr(`ISD_SR_BYTE_POINTER, 32'h1);
            i_load_lane = 2'h1;
            op(`ISD_OP_LOAD_BYTE, 32'(s) << 20, 32'h0, 32'h0);
            chk(o_result, s ? 32'hfffffff4 : 32'h000000f4);
            chk({30'h0, o_byte_pointer}, s ? 32'h3 : 32'h1);
            i_load_lane = 2'h2;
            op(`ISD_OP_LOAD_HALF, 32'(s) << 20, 32'h0, 32'h0);
            chk(o_result, s ? 32'hffff86f8 : 32'h000086f8);
        end
        $display("t_load finished");
    endtask
    task automatic t_store;
        logic [3:0] m;
        for (int l = 0; l < 4; l++) begin
            i_store_lane = 2'(l);
            op(`ISD_OP_STORE_BYTE, 32'h0, 32'hcafebead, 32'hcafebead);
            m = 4'b1000 >> l;
            chk({28'h0, o_store_lanes}, {28'h0, m});
            chk(o_store_data & mask(m), 32'hadadadad & mask(m));
            op(`ISD_OP_STORE_HALF, 32'h0, 32'hcafebead, 32'hcafebead);
            m = l[1] ? 4'b0011 : 4'b1100;
            chk({28'h0, o_store_lanes}, {28'h0, m});
            chk(o_store_data & mask(m), 32'hbeadbead & mask(m));
        end
        wsr(`ISD_SR_BYTE_POINTER, 32'h0);
        op(`ISD_OP_STORE_WORD, 32'h00100000, 32'h1, 32'h1);
        chk({30'h0, o_byte_pointer}, 32'h3);
        $display("t_store finished");
    endtask
    task automatic t_cmp;
        op(`ISD_OP_BYTE_COMPARE, 32'h0, 32'h12345678, 32'hff34ffff);
        chk(o_result, 32'h80000000);
        op(`ISD_OP_BYTE_COMPARE, 32'h0, 32'h12345678, 32'h21436587);
        chk(o_result, 32'h00000000);
        op(`ISD_OP_COMPARE_EQ, 32'h0, 32'h5, 32'h5);
        chk(o_result, 32'h80000000);
        wsr(`ISD_SR_SHIFT_COUNT, 32'h8);
        op(`ISD_OP_FUNNEL, 32'h0, 32'h12345678, 32'h9abcdef0);
        chk({31'h0, o_result_valid}, 32'h0);
        @(negedge i_clk);
        chk({31'h0, o_result_valid}, 32'h1);
        chk(o_result, 32'h3456789a);
        $display("t_cmp finished");
    endtask
    task automatic print_verdict;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge i_clk);
        fails++;
        print_verdict;
    end
    initial begin
        repeat (2) @(negedge i_clk);
        i_reset = 1'b0;
        t_const;
        t_sr;
        t_byte;
        t_half;
        t_load;
        t_store;
        t_cmp;
        print_verdict;
    end
endmodule // test_integer_subword_datapath
`default_nettype wire
